// ==== hw/tig_pkg.sv ====
// Constants and types shared by the transmit gap timer files.
package tig_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [15:0] TIG_CTRL_OFS     = 16'h0400;
    localparam logic [15:0] TIG_STAT_OFS     = 16'h0404;
    localparam logic [15:0] TIG_GAP_OFS      = 16'h0410;

    // Gap timing fields
    localparam int          TIG_B2B_LSB      = 0;
    localparam int          TIG_FIRST_LSB    = 10;
    localparam int          TIG_TOTAL_LSB    = 20;
    localparam int          TIG_FLD_W        = 10;
    localparam logic [9:0]  TIG_B2B_RST      = 10'h00a;
    localparam logic [9:0]  TIG_FIRST_RST    = 10'h008;
    localparam logic [9:0]  TIG_TOTAL_RST    = 10'h006;

    // Control fields
    localparam int          TIG_SPEED_LSB    = 0;
    localparam int          TIG_HALF_BIT     = 2;
    localparam int          TIG_SERDES_BIT   = 3;
    localparam logic [1:0]  TIG_SPEED_RST    = 2'h0;

    // Status fields
    localparam int          TIG_STATE_LSB    = 0;
    localparam int          TIG_COUNT_LSB    = 2;

    // Hidden overhead added to the back-to-back and total gap settings
    localparam logic [10:0] TIG_COPPER_EXTRA = 11'h004;
    localparam logic [10:0] TIG_SERDES_EXTRA = 11'h00a;
    localparam logic [10:0] TIG_TOTAL_EXTRA  = 11'h006;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int          TIG_PCLK_NS      = 10;
    localparam int          TIG_MAC_1G_NS    = 8;
    localparam int          TIG_MAC_100M_NS  = 80;
    localparam int          TIG_MAC_10M_NS   = 800;
    localparam int          TIG_CYC_1G       = (TIG_MAC_1G_NS + TIG_PCLK_NS - 1) / TIG_PCLK_NS;
    localparam int          TIG_CYC_100M     = (TIG_MAC_100M_NS + TIG_PCLK_NS - 1) / TIG_PCLK_NS;
    localparam int          TIG_CYC_10M      = (TIG_MAC_10M_NS + TIG_PCLK_NS - 1) / TIG_PCLK_NS;

    localparam int          TIG_CNT_W        = 11;

    typedef enum logic [1:0] {
        TIG_SPD_1G   = 2'h0,
        TIG_SPD_100M = 2'h1,
        TIG_SPD_10M  = 2'h2
    } tig_speed_t;

    typedef enum logic [1:0] {
        TIG_ST_IDLE  = 2'h0,
        TIG_ST_FIRST = 2'h1,
        TIG_ST_REST  = 2'h3
    } tig_state_t;

endpackage

// ==== hw/tig_cnt_if.sv ====
// Interface between the gap timer control and its gap counter.
`timescale 1ns/1ps
interface tig_cnt_if;
    import tig_pkg::*;
    logic                 clear;
    logic                 tick;
    logic [TIG_CNT_W-1:0] target;
    logic [TIG_CNT_W-1:0] count;
    logic                 done;

    modport ctl (output clear, output tick, output target, input count, input done);
    modport cnt (input clear, input tick, input target, output count, output done);
endinterface

// ==== hw/tig_gap_counter.sv ====
// Gap counter: counts MAC clock ticks up to a target, restartable.
`timescale 1ns/1ps
module tig_gap_counter
    import tig_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    tig_cnt_if.cnt    cif
);

    logic [TIG_CNT_W-1:0] count_q;

    // Clear wins over a tick; the count parks once it meets the target
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= '0;
        end else if (cif.clear) begin
            count_q <= '0;
        end else if (cif.tick && (count_q != cif.target)) begin
            count_q <= count_q + 11'h001;
        end
    end

    assign cif.count = count_q;
    assign cif.done  = (count_q == cif.target);

endmodule

// ==== hw/tig_gap_timer.sv ====
// Transmit inter-packet gap timer with APB register slave.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
module tig_gap_timer
    import tig_pkg::*;
#(
    parameter int ADDR_W = 16
)
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              tx_end,
    input  wire logic              tx_back_to_back,
    input  wire logic              carrier_sense,
    output logic                   tx_allow,
    output logic                   gap_done
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    tig_cnt_if cif ();

    logic [31:0]          prdata_q;
    logic                 pready_q;
    logic                 pslverr_q;
    logic [9:0]           b2b_gap_q;
    logic [9:0]           first_gap_q;
    logic [9:0]           total_gap_q;
    tig_speed_t           speed_q;
    logic                 half_duplex_q;
    logic                 serdes_q;
    logic                 crs_meta_q;
    logic                 crs_sync_q;
    logic [6:0]           div_q;
    logic                 tick_q;
    tig_state_t           state_q;
    tig_state_t           state_d;
    logic [TIG_CNT_W-1:0] target_q;
    logic [TIG_CNT_W-1:0] target_d;
    logic [TIG_CNT_W-1:0] first_q;
    logic                 clear_d;
    logic                 tx_allow_q;
    logic                 gap_done_q;
    logic                 wr_en;
    logic                 rd_setup;
    logic [TIG_CNT_W-1:0] b2b_eff;
    logic [TIG_CNT_W-1:0] total_eff;

    ////////////////////////////////////////////////////////////////////////
    // Functions

    // Pclk cycles per MAC clock; 8 ns rounds up to one 10 ns cycle
    function automatic logic [6:0] mac_cycles(input tig_speed_t spd);
        case (spd)
            TIG_SPD_1G:   mac_cycles = 7'(TIG_CYC_1G);
            TIG_SPD_100M: mac_cycles = 7'(TIG_CYC_100M);
            TIG_SPD_10M:  mac_cycles = 7'(TIG_CYC_10M);
            default:      mac_cycles = 7'(TIG_CYC_1G);
        endcase
    endfunction

    // Register field widened to counter width plus overhead
    function automatic logic [TIG_CNT_W-1:0] add_extra(input logic [9:0] fld, input logic [10:0] extra);
        add_extra = {1'b0, fld} + extra;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // APB slave

    assign wr_en    = psel && penable && pready_q && pwrite;
    assign rd_setup = psel && !penable && !pwrite;

    // One wait-free access phase: ready is raised right after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= psel && !penable;
            pslverr_q <= psel && !penable && (paddr[15:0] != TIG_CTRL_OFS) &&
                         (paddr[15:0] != TIG_STAT_OFS) && (paddr[15:0] != TIG_GAP_OFS);
        end
    end

    // Read data captured during setup; unmapped reads return zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
        end else if (rd_setup) begin
            case (paddr[15:0])
                TIG_GAP_OFS:  prdata_q <= {2'b00, total_gap_q, first_gap_q, b2b_gap_q};
                TIG_CTRL_OFS: prdata_q <= {28'h0, serdes_q, half_duplex_q, speed_q};
                TIG_STAT_OFS: prdata_q <= {19'h0, cif.count, state_q};
                default:      prdata_q <= '0;
            endcase
        end else if (!psel) begin
            prdata_q <= '0;
        end
    end

    // Gap timing register; reserved top bits are not stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            b2b_gap_q   <= TIG_B2B_RST;
            first_gap_q <= TIG_FIRST_RST;
            total_gap_q <= TIG_TOTAL_RST;
        end else if (wr_en && (paddr[15:0] == TIG_GAP_OFS)) begin
            b2b_gap_q   <= pwdata[TIG_B2B_LSB +: TIG_FLD_W];
            first_gap_q <= pwdata[TIG_FIRST_LSB +: TIG_FLD_W];
            total_gap_q <= pwdata[TIG_TOTAL_LSB +: TIG_FLD_W];
        end
    end

    // Link configuration register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed_q       <= TIG_SPD_1G;
            half_duplex_q <= 1'b0;
            serdes_q      <= 1'b0;
        end else if (wr_en && (paddr[15:0] == TIG_CTRL_OFS)) begin
            speed_q       <= tig_speed_t'(pwdata[TIG_SPEED_LSB +: 2]);
            half_duplex_q <= pwdata[TIG_HALF_BIT];
            serdes_q      <= pwdata[TIG_SERDES_BIT];
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    ////////////////////////////////////////////////////////////////////////
    // Carrier synchroniser and MAC clock tick

    // Carrier comes from the PHY pins, so two flops before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crs_meta_q <= 1'b0;
            crs_sync_q <= 1'b0;
        end else begin
            crs_meta_q <= carrier_sense;
            crs_sync_q <= crs_meta_q;
        end
    end

    // Free-running divider; a leftover slow count is cut short so a faster speed takes hold at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else if ((div_q == 7'h00) || (div_q >= mac_cycles(speed_q))) begin
            div_q  <= mac_cycles(speed_q) - 7'h01;
            tick_q <= 1'b1;
        end else begin
            div_q  <= div_q - 7'h01;
            tick_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Gap sequencer

    // Effective gaps include the hidden MAC overhead
    assign b2b_eff   = add_extra(b2b_gap_q, serdes_q ? TIG_SERDES_EXTRA : TIG_COPPER_EXTRA);
    assign total_eff = add_extra(total_gap_q, TIG_TOTAL_EXTRA);

    always_comb begin
        state_d  = state_q;
        target_d = target_q;
        clear_d  = 1'b0;
        case (state_q)
            TIG_ST_IDLE: begin
                if (tx_end) begin
                    clear_d = 1'b1;
                    if (tx_back_to_back) begin
                        target_d = b2b_eff;
                        state_d  = TIG_ST_REST;
                    end else begin
                        target_d = total_eff;
                        state_d  = half_duplex_q ? TIG_ST_FIRST : TIG_ST_REST;
                    end
                end
            end
            TIG_ST_FIRST: begin
                if (crs_sync_q) begin
                    clear_d = 1'b1;
                end else if (cif.count >= first_q) begin
                    state_d = TIG_ST_REST;
                end
            end
            TIG_ST_REST: begin
                if (cif.done) begin
                    state_d = TIG_ST_IDLE;
                end
            end
            default: begin
                state_d = TIG_ST_IDLE;
            end
        endcase
    end

    // State, target and first-portion length latched per gap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q  <= TIG_ST_IDLE;
            target_q <= '0;
            first_q  <= '0;
        end else begin
            state_q  <= state_d;
            target_q <= target_d;
            if (state_q == TIG_ST_IDLE) begin
                first_q <= {1'b0, first_gap_q};
            end
        end
    end

    // Frame release and completion strobe, registered to the ports
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_allow_q <= 1'b1;
            gap_done_q <= 1'b0;
        end else begin
            tx_allow_q <= (state_d == TIG_ST_IDLE);
            gap_done_q <= (state_q == TIG_ST_REST) && (state_d == TIG_ST_IDLE);
        end
    end

    assign tx_allow = tx_allow_q;
    assign gap_done = gap_done_q;

    assign cif.clear  = clear_d;
    assign cif.tick   = tick_q;
    assign cif.target = target_d;

    tig_gap_counter u_counter (
        .pclk    (pclk),
        .presetn (presetn),
        .cif     (cif)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_gap_start;
        (state_q == TIG_ST_IDLE) && tx_end;
    endsequence

    sequence s_quiet_1g;
        tick_q ##1 tick_q;
    endsequence

    // First portion running with the line quiet
    sequence s_first_quiet;
        (state_q == TIG_ST_FIRST) && !crs_sync_q;
    endsequence

    chk_reserved_zero: assert property (
        rd_setup && (paddr[15:0] == TIG_GAP_OFS) |=> (prdata[31:30] == 2'b00))
        else $error("reserved gap bits read non-zero");

    chk_b2b_copper: assert property (
        s_gap_start and (tx_back_to_back && !serdes_q) |=> (target_q == {1'b0, $past(b2b_gap_q)} + 11'h004))
        else $error("copper back-to-back target wrong");

    chk_b2b_serdes: assert property (
        s_gap_start and (tx_back_to_back && serdes_q) |=> (target_q == {1'b0, $past(b2b_gap_q)} + 11'h00a))
        else $error("serdes back-to-back target wrong");

    chk_total_target: assert property (
        s_gap_start and !tx_back_to_back |=> (target_q == {1'b0, $past(total_gap_q)} + 11'h006))
        else $error("total gap target wrong");

    chk_tick_1g: assert property (
        (speed_q == TIG_SPD_1G) && tick_q && (div_q == 7'h00) |=> s_quiet_1g)
        else $error("gigabit tick not every cycle");

    chk_tick_10m: assert property (
        (speed_q == TIG_SPD_10M) && $stable(speed_q) && tick_q |-> (div_q == 7'h4f))
        else $error("10M tick reload wrong");

    chk_div_count: assert property (
        (div_q != 7'h00) && $stable(speed_q) |=> (div_q == $past(div_q) - 7'h01) && !tick_q)
        else $error("MAC clock divider skipped");

    chk_tick_100m: assert property (
        (speed_q == TIG_SPD_100M) && $stable(speed_q) && tick_q && (div_q == 7'h07)
        |=> !tick_q [*7] ##1 tick_q)
        else $error("100M tick spacing wrong");

    chk_carrier_restart: assert property (
        (state_q == TIG_ST_FIRST) && crs_sync_q |=> (cif.count == 11'h000))
        else $error("carrier did not restart first portion");

    chk_no_late_restart: assert property (
        (state_q == TIG_ST_REST) && tick_q && !cif.done |=> (cif.count == $past(cif.count) + 11'h001))
        else $error("count disturbed after first portion");

    chk_full_duplex_skip: assert property (
        s_gap_start and !half_duplex_q |=> (state_q == TIG_ST_REST))
        else $error("first portion used in full duplex");

    chk_hold_frame: assert property (
        s_gap_start |=> !tx_allow ##0 (state_q != TIG_ST_IDLE))
        else $error("frame not held at gap start");

    chk_done_at_target: assert property (
        gap_done |-> tx_allow && ($past(cif.count) == $past(target_q)))
        else $error("gap ended before target");

    chk_gap_write: assert property (
        wr_en && (paddr[15:0] == TIG_GAP_OFS)
        |=> ({total_gap_q, first_gap_q, b2b_gap_q} == $past(pwdata[29:0])))
        else $error("gap fields not stored from write");

    chk_read_back: assert property (
        rd_setup && (paddr[15:0] == TIG_GAP_OFS)
        |=> (prdata == {2'b00, $past(total_gap_q), $past(first_gap_q), $past(b2b_gap_q)}))
        else $error("gap register read back wrong");

    chk_first_hold: assert property (
        s_first_quiet ##0 (cif.count < first_q) |=> (state_q == TIG_ST_FIRST))
        else $error("first portion left early");

    chk_first_exit: assert property (
        s_first_quiet ##0 (cif.count >= first_q) |=> (state_q == TIG_ST_REST))
        else $error("first portion did not end");

    chk_rest_no_clear: assert property (
        (state_q == TIG_ST_REST) |-> !cif.clear)
        else $error("count cleared after first portion");

    chk_half_first: assert property (
        s_gap_start ##0 (!tx_back_to_back && half_duplex_q) |=> (state_q == TIG_ST_FIRST))
        else $error("half duplex first portion skipped");

    chk_b2b_direct: assert property (
        s_gap_start ##0 tx_back_to_back |=> (state_q == TIG_ST_REST))
        else $error("back-to-back gap took first portion");

    chk_start_clear: assert property (
        s_gap_start |-> cif.clear)
        else $error("gap count not restarted at frame end");

    chk_allow_idle: assert property (
        tx_allow == (state_q == TIG_ST_IDLE))
        else $error("frame release out of step with gap");

endmodule

// ==== tb/tig_line_model.sv ====
// Model of the MAC transmit side and the line carrier seen by the gap timer.
`timescale 1ns/1ps
module tig_line_model (
    input  wire logic pclk,
    input  wire logic tx_allow,
    output logic      tx_end,
    output logic      tx_back_to_back,
    output logic      carrier_sense
);
    // Quiet line at time zero
    initial begin
        tx_end = 1'b0;
        tx_back_to_back = 1'b0;
        carrier_sense = 1'b0;
    end

    ////////////////////////////////////////////////////////////
    // End one frame, then, if car is positive, a two-cycle carrier burst car edges later
    task automatic send(input logic b2b, input int car);
        // Only tx_allow high or the bench timeout ends this wait
        while (tx_allow !== 1'b1) begin
            @(posedge pclk);
        end
        tx_end <= 1'b1;
        tx_back_to_back <= b2b;
        @(posedge pclk);
        tx_end <= 1'b0;
        tx_back_to_back <= ~b2b; // Qualifier is stale now, so flip it
        if (car > 0) begin
            repeat (car - 1) @(posedge pclk);
            carrier_sense <= 1'b1;
            repeat (2) @(posedge pclk);
            carrier_sense <= 1'b0;
        end
    endtask
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the transmit gap timer.
`timescale 1ns/1ps
module tb_top;
    import tig_pkg::*;
    typedef struct { logic [32:0] lo; logic [32:0] hi; } tig_exp_t;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, seed;
    logic        pready, pslverr, tx_end, tx_back_to_back, carrier_sense, tx_allow, gap_done, gap_run;
    int          error_cnt, checks, cyc, gap_len, per, b, tot, t;
    tig_exp_t    rd_q[$], gap_q[$];

    tig_gap_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_end(tx_end), .tx_back_to_back(tx_back_to_back), .carrier_sense(carrier_sense),
        .tx_allow(tx_allow), .gap_done(gap_done));
    tig_line_model u_phy (.pclk(pclk), .tx_allow(tx_allow), .tx_end(tx_end),
        .tx_back_to_back(tx_back_to_back), .carrier_sense(carrier_sense));

    // 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////
    // Verdict, shared by the main sequence and the timeout
    task automatic conclude();
        if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Hang guard, well above the longest 10M gaps
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            conclude();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // One APB transfer; holds everything until pready is seen
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No assumed wait count; the bench timeout ends a hung access
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [15:0] a, input logic [32:0] e);
        rd_q.push_back('{e, e});
        apb(1'b0, a, 32'h0);
    endtask

    // Note an accepted gap length range, end a frame, wait for the result
    task automatic gap(input logic b2b, input int car, input int lo, input int hi);
        gap_q.push_back('{33'(lo), 33'(hi)});
        u_phy.send(b2b, car);
        while (gap_q.size() != 0) @(posedge pclk);
        @(posedge pclk);
    endtask

    task automatic cmp_rd(input logic [32:0] v);
        tig_exp_t e;
        e = (rd_q.size() != 0) ? rd_q.pop_front() : '{33'h1ffffffff, 33'h0};
        checks++;
        if (v !== e.lo) begin
            error_cnt++;
            $display("[FAIL] %0t read got %h exp %h", $time, v, e.lo);
        end
    endtask

    task automatic cmp_gap(input logic [32:0] v);
        tig_exp_t e;
        e = (gap_q.size() != 0) ? gap_q.pop_front() : '{33'h1ffffffff, 33'h0};
        checks++;
        if ((v >= e.lo && v <= e.hi) !== 1'b1) begin
            error_cnt++;
            $display("[FAIL] %0t gap got %h exp %h..%h", $time, v, e.lo, e.hi);
        end
    endtask

    ////////////////////////////////////////////////////////////
    // Monitor: read data at pready, gap length from tx_end to gap_done
    always @(posedge pclk) begin
        if (presetn && psel && penable && pready === 1'b1 && !pwrite)
            cmp_rd({pslverr, prdata});
        if (gap_run && gap_done === 1'b1) begin
            cmp_gap(33'(gap_len));
            gap_run = 1'b0;
        end
        else if (gap_run)
            gap_len++;
        else if (tx_end && tx_allow === 1'b1) begin
            gap_run = 1'b1;
            gap_len = 1;
        end
    end

    // Main sequence
    initial begin
        seed = 32'd15364;
        error_cnt = 0;
        checks = 0;
        cyc = 0;
        gap_run = 1'b0;
        gap_len = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0;
        pwdata = 32'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(TIG_GAP_OFS, {1'b0, 32'h0060200a});
        rd(TIG_CTRL_OFS, 33'h0);
        rd(TIG_STAT_OFS, 33'h0);
        rd(16'h0800, {1'b1, 32'h0});
        // Reserved bits set on purpose: they must read back as zero
        apb(1'b1, TIG_GAP_OFS, 32'hc0000000 | (rnd() & 32'h3fffffff));
        rd(TIG_GAP_OFS, {1'b0, 2'b00, seed[29:0]});
        // Every speed, with copper b2b, serdes b2b and full duplex non-b2b
        for (int s = 0; s < 3; s++) begin
            per = (s == 0) ? 1 : ((s == 1) ? 8 : 80);
            for (int m = 0; m < 3; m++) begin
                b = 2 + int'(rnd() % 32'd8);
                tot = 2 + int'(rnd() % 32'd8);
                apb(1'b1, TIG_GAP_OFS, {2'b00, 10'(tot), 10'h008, 10'(b)});
                apb(1'b1, TIG_CTRL_OFS, {28'h0, m == 1, 1'b0, 2'(s)});
                t = (m == 2) ? tot + 6 : ((m == 1) ? b + 10 : b + 4);
                gap(m != 2, (m == 2) ? 3 : 0, (t - 1) * per + 1, t * per + 3);
            end
        end
        // Half duplex: total 20, first 8, target 26 clocks
        apb(1'b1, TIG_GAP_OFS, 32'h01402008);
        apb(1'b1, TIG_CTRL_OFS, 32'h00000004);
        gap(1'b0, 4, 30, 38);
        gap(1'b0, 14, 26, 29);
        // Mid-run reset: settings fall back to the recommended values
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(TIG_GAP_OFS, {1'b0, 32'h0060200a});
        gap(1'b1, 0, 14, 17);
        gap(1'b0, 0, 12, 15);
        conclude();
    end
endmodule
